// ==== hdl/tsicc_pkg.sv ====
/*
 Package for the connection control block of the slot switch: register
 offsets, connection word field layout, reset values and bus carriers.
 Assumes a single 250 MHz clock domain and a plain register port.
*/
package tsicc_pkg;

   localparam int          N_STREAMS  = 32;
   localparam int          N_CHANNELS = 32;
   localparam int          CW_DEPTH   = N_STREAMS * N_CHANNELS;

   // Register map, word addresses on the plain port
   localparam logic [11:0] ADDR_CTRL     = 12'h000;
   localparam logic [11:0] ADDR_ALIGN    = 12'h001;
   localparam logic [11:0] ADDR_IRQ_STAT = 12'h002;
   localparam logic [11:0] ADDR_IRQ_EN   = 12'h003;
   localparam logic [11:0] ADDR_IRQ_CLR  = 12'h004;
   localparam logic [11:0] ADDR_CW_BASE  = 12'h400;

   // Control register fields
   localparam int          CTRL_STANDBY_BIT = 3;
   localparam int          CTRL_EVAL_BIT    = 2;
   localparam logic [15:0] CTRL_RESET       = 16'h0000;
   localparam logic [15:0] CTRL_WMASK       = 16'h000C;

   // Frame alignment register
   localparam int          ALIGN_DONE_BIT   = 12;
   localparam logic [11:0] ALIGN_RESET      = 12'h000;

   // Connection word fields
   localparam int          CW_LOOP_BIT      = 15;
   localparam int          CW_CONST_BIT     = 14;
   localparam int          CW_PROC_BIT      = 13;
   localparam int          CW_OE_BIT        = 12;
   localparam int          CW_STREAM_MSB    = 11;
   localparam int          CW_STREAM_LSB    = 7;
   localparam int          CW_CHAN_MSB      = 4;
   localparam int          CW_CHAN_LSB      = 0;
   localparam logic [15:0] CW_RESET         = 16'h0000;

   // Interrupt status bits
   localparam int          IRQ_DONE_BIT     = 0;
   localparam int          IRQ_START_BIT    = 1;
   localparam logic [1:0]  IRQ_RESET        = 2'h0;

   typedef struct packed {
      logic [11:0] addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } tsicc_bus_s;

   typedef struct packed {
      logic        loopback;
      logic        const_delay;
      logic        proc_chan;
      logic        out_en;
      logic [4:0]  src_stream;
      logic [4:0]  src_chan;
      logic [7:0]  proc_byte;
   } tsicc_cw_s;

endpackage

// ==== hdl/tsicc_cw_decode.sv ====
/*
 Connection word decoder: splits one 16-bit word into its fields.
 Assumes the word follows the package layout; bits 6-5 only reach the processor byte.
*/
`timescale 1ns/1ns
module tsicc_cw_decode
(
   // Raw word
   input  wire logic [15:0]         word_i,
   // Decoded fields
   output tsicc_pkg::tsicc_cw_s     cw_o
);

   always_comb
   begin
      cw_o.loopback    = word_i[tsicc_pkg::CW_LOOP_BIT];
      cw_o.const_delay = word_i[tsicc_pkg::CW_CONST_BIT];
      cw_o.proc_chan   = word_i[tsicc_pkg::CW_PROC_BIT];
      cw_o.out_en      = word_i[tsicc_pkg::CW_OE_BIT];
      cw_o.src_stream  =
         word_i[tsicc_pkg::CW_STREAM_MSB:tsicc_pkg::CW_STREAM_LSB];
      cw_o.src_chan    =
         word_i[tsicc_pkg::CW_CHAN_MSB:tsicc_pkg::CW_CHAN_LSB];
      cw_o.proc_byte   = word_i[7:0];
   end

endmodule

// ==== hdl/tsicc_top.sv ====
/*
 Connection control and output drive logic of a 32 stream slot switch.
 Holds 1024 connection words, the switch control register and the
 frame evaluation handshake; drives per-slot route and drive enables.
 Assumes the slot counter, data memory and frame measurement engine
 sit outside and present stream/channel index and a done pulse.
 The register port never stalls; reads answer in the next cycle only.
 Connection words are not reset: software loads every slot it enables
 before the drive pin or the standby bit lets the streams out.
 Delay mode and loopback are only passed on; the data path and the
 per-stream input offsets belong to the switching core outside.
 Interrupt events are the start and the end of a frame evaluation.
*/
`timescale 1ns/1ns
module tsicc_top
(
   // Clock and reset
   input  wire logic        mclk_i,
   input  wire logic        sys_rst_i,
   // Register port
   input  wire logic [11:0] reg_addr_i,
   input  wire logic [15:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [15:0] reg_rdata_o,
   // Pins
   input  wire logic        output_drive_pin_i,
   // Slot being served on the transmit side
   input  wire logic [4:0]  slot_stream_i,
   input  wire logic [4:0]  slot_chan_i,
   // Frame evaluation engine
   input  wire logic        frame_eval_done_i,
   input  wire logic [11:0] frame_delay_i,
   output logic             frame_eval_run_o,
   // Slot outputs
   output logic [4:0]       src_stream_o,
   output logic [4:0]       src_chan_o,
   output logic             const_delay_o,
   output logic             loopback_o,
   output logic             proc_chan_o,
   output logic [7:0]       proc_byte_o,
   output logic             slot_drive_o,
   output logic [31:0]      stream_drive_en_o,
   // Interrupt
   output logic             irq_o
);

   logic [15:0]          cw_mem [tsicc_pkg::CW_DEPTH];
   logic [15:0]          ctrl_reg;
   logic [15:0]          ctrl_next;
   logic                 done_reg;
   logic [11:0]          delay_reg;
   logic                 run_reg;
   logic [1:0]           irq_stat_reg;
   logic [1:0]           irq_en_reg;
   logic [1:0]           irq_set;
   logic [1:0]           irq_clr;
   logic [15:0]          rdata_reg;
   logic [15:0]          reg_word;
   logic [15:0]          align_word;
   logic [15:0]          cw_slot_word;
   tsicc_pkg::tsicc_cw_s cw_dec;
   logic                 global_drive;
   logic                 start_rise;
   logic                 start_fall;
   logic                 done_set;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
      return a == r;
   endfunction

   function automatic logic in_cw(input logic [11:0] a);
      return a[11:10] == tsicc_pkg::ADDR_CW_BASE[11:10];
   endfunction

   // Control register write, only standby and start kept
   // Reserved bits read back zero so software sees them clear
   always_comb
   begin
      ctrl_next = ctrl_reg;
      if (reg_wr_i && hit(reg_addr_i, tsicc_pkg::ADDR_CTRL))
      begin
         ctrl_next = reg_wdata_i & tsicc_pkg::CTRL_WMASK;
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         ctrl_reg <= tsicc_pkg::CTRL_RESET;
      end
      else
      begin
         ctrl_reg <= ctrl_next;
      end
   end

   assign start_rise = ctrl_next[tsicc_pkg::CTRL_EVAL_BIT]
                       && !ctrl_reg[tsicc_pkg::CTRL_EVAL_BIT];
   assign start_fall = !ctrl_next[tsicc_pkg::CTRL_EVAL_BIT]
                       && ctrl_reg[tsicc_pkg::CTRL_EVAL_BIT];
   assign done_set   = run_reg && frame_eval_done_i;

   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         run_reg <= 1'b0;
      end
      else if (start_rise)
      begin
         run_reg <= 1'b1;
      end
      else if (done_set || start_fall)
      begin
         run_reg <= 1'b0;
      end
   end

   // Done flag and measured delay; a late done beats the clear
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         done_reg  <= 1'b0;
         delay_reg <= tsicc_pkg::ALIGN_RESET;
      end
      else if (done_set)
      begin
         done_reg  <= 1'b1;
         delay_reg <= frame_delay_i;
      end
      else if (start_fall)
      begin
         done_reg  <= 1'b0;
         delay_reg <= tsicc_pkg::ALIGN_RESET;
      end
   end

   assign frame_eval_run_o = run_reg;

   // No reset on the words: clearing 1024 of them would cost area
   // Connection memory write; one write port, two read ports
   always_ff @(posedge mclk_i)
   begin
      if (reg_wr_i && in_cw(reg_addr_i))
      begin
         cw_mem[reg_addr_i[9:0]] <= reg_wdata_i;
      end
   end

   always_ff @(posedge mclk_i)
   begin
      cw_slot_word <= cw_mem[{slot_stream_i, slot_chan_i}];
   end

   tsicc_cw_decode u_decode
   (
      .word_i (cw_slot_word),
      .cw_o   (cw_dec)
   );

   assign global_drive = output_drive_pin_i
                         || ctrl_reg[tsicc_pkg::CTRL_STANDBY_BIT];

   // Slot outputs registered one cycle after the memory read
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         src_stream_o  <= 5'h00;
         src_chan_o    <= 5'h00;
         const_delay_o <= 1'b0;
         loopback_o    <= 1'b0;
         proc_chan_o   <= 1'b0;
         proc_byte_o   <= 8'h00;
      end
      else
      begin
         src_stream_o  <= cw_dec.src_stream;
         src_chan_o    <= cw_dec.src_chan;
         const_delay_o <= cw_dec.const_delay;
         loopback_o    <= cw_dec.loopback;
         proc_chan_o   <= cw_dec.proc_chan;
         proc_byte_o   <= cw_dec.proc_byte;
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         slot_drive_o <= 1'b0;
      end
      else
      begin
         slot_drive_o <= global_drive && cw_dec.out_en;
      end
   end

   // Per-stream global enable, one line per transmit driver
   genvar s;
   generate
      for (s = 0; s < tsicc_pkg::N_STREAMS; s++)
      begin : g_drv
         always_ff @(posedge mclk_i)
         begin
            if (sys_rst_i)
            begin
               stream_drive_en_o[s] <= 1'b0;
            end
            else
            begin
               stream_drive_en_o[s] <= global_drive;
            end
         end
      end
   endgenerate

   // Event and clear masks laid out by the status bit numbers
   always_comb
   begin
      irq_set                           = 2'h0;
      irq_set[tsicc_pkg::IRQ_DONE_BIT]  = done_set;
      irq_set[tsicc_pkg::IRQ_START_BIT] = start_rise;
      irq_clr                           = 2'h0;
      if (reg_wr_i && hit(reg_addr_i, tsicc_pkg::ADDR_IRQ_CLR))
      begin
         irq_clr = reg_wdata_i[1:0];
      end
   end

   // Interrupt enable, plain read and write
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         irq_en_reg <= tsicc_pkg::IRQ_RESET;
      end
      else if (reg_wr_i && hit(reg_addr_i, tsicc_pkg::ADDR_IRQ_EN))
      begin
         irq_en_reg <= reg_wdata_i[1:0];
      end
   end

   // Interrupt status: set wins over clear so no event is lost
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         irq_stat_reg <= tsicc_pkg::IRQ_RESET;
      end
      else
      begin
         irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
      end
   end

   assign irq_o = |(irq_stat_reg & irq_en_reg);

   // Alignment word: done flag above the measured delay
   always_comb
   begin
      align_word                            = 16'h0000;
      align_word[11:0]                      = delay_reg;
      align_word[tsicc_pkg::ALIGN_DONE_BIT] = done_reg;
   end

   always_comb
   begin
      reg_word = 16'h0000;
      if (hit(reg_addr_i, tsicc_pkg::ADDR_CTRL))
      begin
         reg_word = ctrl_reg;
      end
      else if (hit(reg_addr_i, tsicc_pkg::ADDR_ALIGN))
      begin
         reg_word = align_word;
      end
      else if (hit(reg_addr_i, tsicc_pkg::ADDR_IRQ_STAT))
      begin
         reg_word = {14'h0000, irq_stat_reg};
      end
      else if (hit(reg_addr_i, tsicc_pkg::ADDR_IRQ_EN))
      begin
         reg_word = {14'h0000, irq_en_reg};
      end
   end

   // Read data, valid the cycle after the strobe only, zero otherwise
   // Memory words share the flop, so the output comes from a register
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i || !reg_rd_i)
      begin
         rdata_reg <= 16'h0000;
      end
      else if (in_cw(reg_addr_i))
      begin
         rdata_reg <= cw_mem[reg_addr_i[9:0]];
      end
      else
      begin
         rdata_reg <= reg_word;
      end
   end

   assign reg_rdata_o = rdata_reg;

endmodule

// ==== test/tsicc_properties.sv ====
/*
 Checker for the connection control block, bound to its top module.
 Assumes connection words are written before their slot is served.
*/
`timescale 1ns/1ns
module tsicc_properties
(
   // Clock, reset, register port
   input  wire logic        mclk_i,
   input  wire logic        sys_rst_i,
   input  wire logic [11:0] reg_addr_i,
   input  wire logic [15:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   // Pins and slot index
   input  wire logic        output_drive_pin_i,
   input  wire logic [4:0]  slot_stream_i,
   input  wire logic [4:0]  slot_chan_i,
   input  wire logic        frame_eval_done_i,
   // Watched outputs
   input  wire logic        frame_eval_run_o,
   input  wire logic [4:0]  src_stream_o,
   input  wire logic [4:0]  src_chan_o,
   input  wire logic        const_delay_o,
   input  wire logic        loopback_o,
   input  wire logic        proc_chan_o,
   input  wire logic [7:0]  proc_byte_o,
   input  wire logic        slot_drive_o,
   input  wire logic [31:0] stream_drive_en_o
);
   logic          sb_q;
   logic          ev_q;
   logic [15:0]   mem [1024];
   logic [1023:0] vld;
   logic [15:0]   w1;
   logic [15:0]   w2;
   logic          v1;
   logic          v2;
   wire logic     ctl_wr = reg_wr_i && reg_addr_i == tsicc_pkg::ADDR_CTRL;
   wire logic     cw_wr  = reg_wr_i && reg_addr_i[11:10] == 2'h1;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   // Shadow only trusts words written since the last reset
   always_ff @(posedge mclk_i)
   begin
      sb_q <= sys_rst_i ? 1'h0 : ctl_wr ? reg_wdata_i[3] : sb_q;
      ev_q <= sys_rst_i ? 1'h0 : ctl_wr ? reg_wdata_i[2] : ev_q;
      if (cw_wr)
         mem[reg_addr_i[9:0]] <= reg_wdata_i;
      if (sys_rst_i)
         vld <= '0;
      else if (cw_wr)
         vld[reg_addr_i[9:0]] <= 1'h1;
      w1 <= mem[{slot_stream_i, slot_chan_i}];
      w2 <= w1;
      v1 <= vld[{slot_stream_i, slot_chan_i}] && !sys_rst_i;
      v2 <= v1 && !sys_rst_i;
   end
   drive_off_a: assert property (
      !$past(sys_rst_i) && $past(!output_drive_pin_i && !sb_q)
      |-> stream_drive_en_o == 32'h0)
      else $error("drivers on with pin and standby low");
   drive_on_a: assert property (
      !$past(sys_rst_i) && $past(output_drive_pin_i || sb_q)
      |-> stream_drive_en_o == 32'hFFFFFFFF)
      else $error("drivers off with pin or standby high");
   eval_start_a: assert property (
      ctl_wr && reg_wdata_i[2] && !ev_q |=> frame_eval_run_o)
      else $error("rising start did not begin evaluation");
   eval_stop_a: assert property (
      frame_eval_run_o && frame_eval_done_i |=> !frame_eval_run_o)
      else $error("evaluation kept running after done");
   eval_clear_a: assert property (
      ctl_wr && !reg_wdata_i[2] && ev_q |=> !frame_eval_run_o)
      else $error("falling start did not stop evaluation");
   route_field_a: assert property (
      v2 |-> src_stream_o == w2[11:7] && src_chan_o == w2[4:0])
      else $error("source stream or channel wrong");
   mode_bits_a: assert property (
      v2 |-> {loopback_o, const_delay_o, proc_chan_o} == w2[15:13])
      else $error("loopback, delay or processor mode wrong");
   proc_byte_a: assert property (
      v2 && w2[13] |-> proc_byte_o == w2[7:0])
      else $error("processor byte wrong");
   slot_drive_a: assert property (
      v2 |-> slot_drive_o == (w2[12] && stream_drive_en_o[0]))
      else $error("slot drive disagrees with enables");
endmodule

bind tsicc_top tsicc_properties u_props
(
   .mclk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
   .output_drive_pin_i, .slot_stream_i, .slot_chan_i, .frame_eval_done_i,
   .frame_eval_run_o, .src_stream_o, .src_chan_o, .const_delay_o,
   .loopback_o, .proc_chan_o, .proc_byte_o, .slot_drive_o,
   .stream_drive_en_o
);

// ==== test/tsicc_eval_engine.sv ====
/*
 Model of the frame measurement engine beside the block.
 Assumes run from the block; answers lat_i+1 cycles after run rises.
*/
`timescale 1ns/1ns
module tsicc_eval_engine
#(
   parameter logic [11:0] DLY = 12'h5A3
)
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        run_i,
   input  wire logic [7:0]  lat_i,
   output logic             done_o,
   output logic [11:0]      delay_o
);
   logic [7:0] cnt_reg;
   always_ff @(posedge clk_i)
   begin
      cnt_reg <= (rst_i || !run_i) ? 8'h00 : cnt_reg + 8'h01;
      done_o  <= !rst_i && run_i && !done_o && cnt_reg == lat_i;
   end
   // Delay only means something with done, so it wanders otherwise
   assign delay_o = done_o ? DLY : ~DLY ^ {4'h0, cnt_reg};
endmodule

// ==== test/tsicc_tb.sv ====
/*
 Self-checking bench for the connection control block.
 Assumes the engine model answers run; slot index driven here.
*/
`timescale 1ns/1ns
module testbench;
   localparam logic [11:0] DLY = 12'h5A3;
   logic        clk;
   logic        rst = 1'h1;
   logic [11:0] addr = 12'h000;
   logic [15:0] wdata = 16'h0000;
   logic        wr = 1'h0;
   logic        rd = 1'h0;
   logic        pin = 1'h0;
   logic [4:0]  s_str = 5'h00;
   logic [4:0]  s_chn = 5'h00;
   logic [7:0]  lat = 8'h00;
   logic [15:0] rdata;
   logic [11:0] dly;
   logic        done, run, cdel, channel_loopback, pchn, sdrv, irq;
   logic [4:0]  sstr, schn;
   logic [7:0]  pbyte;
   logic [31:0] den;
   int          n_errors = 0;
   int          check_count = 0;
   tsicc_top uut (.mclk_i(clk), .sys_rst_i(rst), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .output_drive_pin_i(pin), .slot_stream_i(s_str), .slot_chan_i(s_chn),
      .frame_eval_done_i(done), .frame_delay_i(dly), .frame_eval_run_o(run),
      .src_stream_o(sstr), .src_chan_o(schn), .const_delay_o(cdel),
      .loopback_o(channel_loopback), .proc_chan_o(pchn), .proc_byte_o(pbyte),
      .slot_drive_o(sdrv), .stream_drive_en_o(den), .irq_o(irq));
   tsicc_eval_engine #(.DLY(DLY)) eng (.clk_i(clk), .rst_i(rst),
      .run_i(run), .lat_i(lat), .done_o(done), .delay_o(dly));
   initial
   begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wreg(input logic [11:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
   endtask
   task automatic rreg(input logic [11:0] a, input logic [15:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      #1;
      chk(rdata, e);
   endtask
   task automatic t_regs;
      rreg(tsicc_pkg::ADDR_CTRL, tsicc_pkg::CTRL_RESET);
      wreg(tsicc_pkg::ADDR_CTRL, 16'hFFF3);
      rreg(tsicc_pkg::ADDR_CTRL, 16'h0000);
      wreg(tsicc_pkg::ADDR_ALIGN, 16'hFFFF);
      rreg(tsicc_pkg::ADDR_ALIGN, 16'h0000);
      wreg(12'h005, 16'hFFFF);
      rreg(12'h005, 16'h0000);
   endtask
   task automatic t_drive;
      for (int i = 0; i < 4; i++)
      begin
         wreg(tsicc_pkg::ADDR_CTRL, {12'h000, i[1], 3'h0});
         pin <= i[0];
         settle(3);
         chk(den, (i != 0) ? 32'hFFFFFFFF : 32'h0);
      end
   endtask
   task automatic t_slot;
      logic [15:0] w [3] = '{16'h9F9F, 16'h6015, 16'h5A8C};
      logic [9:0]  ix [3] = '{10'h000, 10'h3FF, 10'h221};
      logic [15:0] c;
      wreg(tsicc_pkg::ADDR_CTRL, 16'h0000);
      // stream offsets sit outside, taken as zero
      // Bits 6-5 kept zero in every word
      for (int i = 0; i < 3; i++)
         wreg(tsicc_pkg::ADDR_CW_BASE | {2'h0, ix[i]}, w[i]);
      // Words read back whole over the register port
      for (int i = 0; i < 3; i++)
         rreg(tsicc_pkg::ADDR_CW_BASE | {2'h0, ix[i]}, w[i]);
      for (int i = 0; i < 6; i++)
      begin
         c = w[i % 3];
         @(posedge clk);
         {s_str, s_chn} <= ix[i % 3];
         pin <= (i < 3);
         settle(3);
         chk({sstr, schn}, {c[11:7], c[4:0]});
         chk({channel_loopback, cdel, pchn}, c[15:13]);
         chk(sdrv, c[12] && i < 3);
         if (c[13])
            chk(pbyte, c[7:0]);
      end
   endtask
   task automatic t_eval;
      for (int i = 0; i < 2; i++)
      begin
         wreg(tsicc_pkg::ADDR_IRQ_EN, i ? 16'h0000 : 16'h0003);
         rreg(tsicc_pkg::ADDR_IRQ_EN, i ? 16'h0000 : 16'h0003);
         lat <= i ? 8'h00 : 8'h07;
         wreg(tsicc_pkg::ADDR_CTRL, 16'h0004);
         settle(1);
         chk({run, irq}, {1'h1, i == 0});
         for (int k = 0; k < 40 && run === 1'h1; k++)
            settle(1);
         chk(run, 1'h0);
         rreg(tsicc_pkg::ADDR_ALIGN, {4'h1, DLY});
         rreg(tsicc_pkg::ADDR_IRQ_STAT, 16'h0003);
         wreg(tsicc_pkg::ADDR_IRQ_CLR, 16'h0003);
         settle(1);
         chk(irq, 1'h0);
         wreg(tsicc_pkg::ADDR_CTRL, 16'h0000);
         rreg(tsicc_pkg::ADDR_ALIGN, 16'h0000);
         // Start stays low for a shortened frame before re-arming
         settle(64);
      end
      lat <= 8'hFF;
      wreg(tsicc_pkg::ADDR_CTRL, 16'h0004);
      settle(3);
      chk(run, 1'h1);
      wreg(tsicc_pkg::ADDR_CTRL, 16'h0000);
      settle(1);
      chk(run, 1'h0);
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk);
      n_errors++;
      wrap_up();
   end
   initial
   begin
      repeat (3) @(posedge clk);
      rst <= 1'h0;
      t_regs();
      t_drive();
      t_slot();
      t_eval();
      wrap_up();
   end
endmodule
